/* File: hdl/uef_event_flags.sv */
// USB event flags, bus-reset vectoring and SRAM routing control.
// Assumes event pulses are on aclk; pins are asynchronous; AXI4-Lite master.
// What this block does
// - Bulk receive data error readable, 1 error
// - Flag bit 0 set on bulk reception
// - Flags stay set until firmware clears
// - Four reset sources are recognised
// - SE0 for 10 ms raises bus reset, vector 9
// - Bus reset state held while SE0 lasts
// - Each flag interrupts only when enabled
// - Vector codes fixed per interrupt source
// - Routing register holds six select bits
// - Bit 5 makes first SRAM bulk buffer
// - Bit 4 makes second SRAM bulk buffer
// - Bulk receive interrupt clears receive ready
//
// The implementer's own choice: the AXI4-Lite register port.
`default_nettype none
module uef_event_flags
    import uef_pkg::*;
#(
    parameter int unsigned SE0_CYCLES = SE0_MIN_CYCLES
)(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Engine events, same clock
    input wire logic [7:0] usb_event_pulses,
    input wire logic bulk_rx_data_error_in,
    input wire logic resume_pulse,
    input wire logic supply_rise_pulse,
    // Asynchronous pins
    input wire logic bus_dp_pin,
    input wire logic bus_dm_pin,
    input wire logic [3:0] reset_src_pins,
    // Results
    output logic irq,
    output logic [3:0] irq_vector,
    output logic bulk_rx_ready,
    output logic [5:0] sram_route,
    output logic usb_engine_reset
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        return addr[ADDR_W-1:2] == idx;
    endfunction

    function automatic logic [3:0] pick_vector(input logic [7:0] fl, input logic [2:0] sy);
        logic [3:0] v;
        v = VEC_NONE;
        if (sy[SYS_SUPPLY])
            v = VEC_SUPPLY;
        if (sy[SYS_RESUME])
            v = VEC_RESUME;
        if (sy[SYS_BUS_RESET])
            v = VEC_BUS_RESET;
        for (int i = 0; i < 8; i++)
        begin
            if (fl[i])
                v = VEC_BULK_RX - 4'(i);
        end
        return v;
    endfunction

    uef_se0_if se0_bus();

    logic acc_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] flags_ff;
    logic [7:0] irq_en_ff;
    logic [7:0] sys_ff;
    logic [7:0] sys_en_ff;
    logic brx_ready_ff;
    logic brx_err_ff;
    logic [5:0] route_ff;
    logic irq_ff;
    logic [3:0] vec_ff;
    logic eng_rst_ff;
    logic [3:0] rsp_s1_ff;
    logic [3:0] rsp_s2_ff;
    logic [3:0] rsp_s3_ff;
    logic wr_en;
    logic [7:0] wr_byte;
    logic wr_mapped;
    logic [7:0] sys_set;
    logic [7:0] pend_flags;
    logic [2:0] pend_sys;
    logic pend_any;
    logic [7:0] rd_byte;
    logic rd_mapped;

    uef_se0_detect #(
        .SE0_CYCLES(SE0_CYCLES)
    ) u_se0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .se0_bus(se0_bus)
    );

    assign se0_bus.dp_pin = bus_dp_pin;
    assign se0_bus.dm_pin = bus_dm_pin;

    // Bus write channel: address and data are taken together
    assign wr_en = acc_ff && s_axi_wstrb[0];
    assign wr_byte = s_axi_wdata[7:0];
    assign wr_mapped = reg_hit(s_axi_awaddr, IDX_EVENT_FLAGS) || reg_hit(s_axi_awaddr, IDX_IRQ_EN)
        || reg_hit(s_axi_awaddr, IDX_SYS_EVENTS) || reg_hit(s_axi_awaddr, IDX_SYS_EN)
        || reg_hit(s_axi_awaddr, IDX_BULK_RX) || reg_hit(s_axi_awaddr, IDX_SRAM_ROUTE);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else
        begin
            acc_ff <= !acc_ff && !bvalid_ff && s_axi_awvalid && s_axi_wvalid;
            if (acc_ff)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    // Reset source pins: synchronise, then catch rising edges
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rsp_s1_ff <= 4'h0;
            rsp_s2_ff <= 4'h0;
            rsp_s3_ff <= 4'h0;
            eng_rst_ff <= 1'b0;
        end
        else
        begin
            rsp_s1_ff <= reset_src_pins;
            rsp_s2_ff <= rsp_s1_ff;
            rsp_s3_ff <= rsp_s2_ff;
            eng_rst_ff <= (|rsp_s2_ff) || se0_bus.in_reset;
        end
    end

    assign sys_set = {rsp_s2_ff & ~rsp_s3_ff, 1'b0, supply_rise_pulse, resume_pulse,
        se0_bus.reset_evt};

    // Sticky event flags, write one to clear; a set in the same cycle wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags_ff <= RST_EVENT_FLAGS;
            sys_ff <= RST_SYS;
        end
        else
        begin
            if (wr_en && reg_hit(s_axi_awaddr, IDX_EVENT_FLAGS))
                flags_ff <= (flags_ff & ~wr_byte) | usb_event_pulses;
            else
                flags_ff <= flags_ff | usb_event_pulses;
            if (wr_en && reg_hit(s_axi_awaddr, IDX_SYS_EVENTS))
                sys_ff <= (sys_ff & ~wr_byte) | sys_set;
            else
                sys_ff <= sys_ff | sys_set;
        end
    end

    // Enables, bulk receive control and routing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_en_ff <= RST_IRQ_EN;
            sys_en_ff <= RST_IRQ_EN;
            brx_ready_ff <= 1'b0;
            brx_err_ff <= 1'b0;
            route_ff <= RST_SRAM_ROUTE;
        end
        else
        begin
            if (wr_en && reg_hit(s_axi_awaddr, IDX_IRQ_EN))
                irq_en_ff <= wr_byte;
            if (wr_en && reg_hit(s_axi_awaddr, IDX_SYS_EN))
                sys_en_ff <= {5'h00, wr_byte[2:0]};
            if (usb_event_pulses[FLAG_BULK_RX])
            begin
                brx_ready_ff <= 1'b0;
                brx_err_ff <= bulk_rx_data_error_in;
            end
            else if (wr_en && reg_hit(s_axi_awaddr, IDX_BULK_RX))
                brx_ready_ff <= wr_byte[BRX_READY_BIT];
            if (wr_en && reg_hit(s_axi_awaddr, IDX_SRAM_ROUTE))
                route_ff <= wr_byte[5:0];
        end
    end

    // Interrupt gating and vector
    assign pend_flags = flags_ff & irq_en_ff;
    assign pend_sys = sys_ff[2:0] & sys_en_ff[2:0];
    assign pend_any = (|pend_flags) || (|pend_sys);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_ff <= 1'b0;
            vec_ff <= VEC_NONE;
        end
        else
        begin
            irq_ff <= pend_any;
            vec_ff <= pick_vector(pend_flags, pend_sys);
        end
    end

    // Read channel
    always_comb
    begin
        rd_byte = 8'h00;
        rd_mapped = 1'b1;
        if (reg_hit(s_axi_araddr, IDX_EVENT_FLAGS))
            rd_byte = flags_ff;
        else if (reg_hit(s_axi_araddr, IDX_IRQ_EN))
            rd_byte = irq_en_ff;
        else if (reg_hit(s_axi_araddr, IDX_SYS_EVENTS))
            rd_byte = sys_ff;
        else if (reg_hit(s_axi_araddr, IDX_SYS_EN))
            rd_byte = sys_en_ff;
        else if (reg_hit(s_axi_araddr, IDX_BULK_RX))
            rd_byte = {brx_ready_ff, 3'h0, brx_err_ff, 3'h0};
        else if (reg_hit(s_axi_araddr, IDX_SRAM_ROUTE))
            rd_byte = {2'h0, route_ff};
        else
            rd_mapped = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end
        else
        begin
            arready_ff <= !arready_ff && !rvalid_ff && s_axi_arvalid;
            if (arready_ff)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h0, rd_byte};
                rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_awready = acc_ff;
    assign s_axi_wready = acc_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign irq = irq_ff;
    assign irq_vector = vec_ff;
    assign bulk_rx_ready = brx_ready_ff;
    assign sram_route = route_ff;
    assign usb_engine_reset = eng_rst_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    bulk_rx_flag_a: assert property (
        usb_event_pulses[FLAG_BULK_RX] |=> flags_ff[FLAG_BULK_RX])
        else $error("bulk receive event did not set flag bit 0");
    flag_sticky_a: assert property (flags_ff[FLAG_BULK_RX]
        && !(acc_ff && reg_hit(s_axi_awaddr, IDX_EVENT_FLAGS)) |=> flags_ff[FLAG_BULK_RX])
        else $error("event flag cleared without a firmware write");
    set_beats_clear_a: assert property (usb_event_pulses[FLAG_SETUP] && wr_en
        && reg_hit(s_axi_awaddr, IDX_EVENT_FLAGS) && wr_byte[FLAG_SETUP]
        |=> flags_ff[FLAG_SETUP])
        else $error("hardware set lost against a same-cycle clear");
    rx_ready_clear_a: assert property (usb_event_pulses[FLAG_BULK_RX] |=> !brx_ready_ff)
        else $error("receive ready not cleared by bulk receive");
    rx_error_bit_a: assert property (usb_event_pulses[FLAG_BULK_RX]
        |=> brx_err_ff == $past(bulk_rx_data_error_in))
        else $error("receive error bit does not follow the packet");
    irq_gate_a: assert property (!pend_any [*2] |-> !irq_ff)
        else $error("interrupt raised with no enabled pending flag");
    irq_raise_a: assert property (pend_any [*2] |-> irq_ff)
        else $error("enabled pending flag did not raise interrupt");
    bus_reset_vec_a: assert property (se0_bus.reset_evt && sys_en_ff[SYS_BUS_RESET]
        && irq_en_ff == 8'h00 ##1 $stable(sys_en_ff) && $stable(irq_en_ff)
        |=> irq_vector == VEC_BUS_RESET && irq)
        else $error("bus reset did not present vector 9");
    route_write_a: assert property (wr_en
        && reg_hit(s_axi_awaddr, IDX_SRAM_ROUTE) |=> sram_route == $past(s_axi_wdata[5:0]))
        else $error("routing register did not take the written bits");
    reset_cause_a: assert property (rsp_s2_ff[0] && !rsp_s3_ff[0] |=> sys_ff[SYS_POR])
        else $error("reset source edge not recorded");

    clear_flag_c: cover property (flags_ff[FLAG_BULK_RX] ##1 wr_en ##1 !flags_ff[FLAG_BULK_RX]);
    bus_reset_irq_c: cover property (se0_bus.reset_evt ##2 irq_vector == VEC_BUS_RESET);
    second_ram_c: cover property (route_ff == 6'h10);
    unmapped_c: cover property (rvalid_ff && rresp_ff == RESP_SLVERR);
endmodule
`default_nettype wire

/* File: hdl/uef_se0_detect.sv */
// SE0 bus-reset detector: synchronises the cable pins and times SE0.
// Assumes the pins are asynchronous and the clock is the core clock.
`default_nettype none
module uef_se0_detect
    import uef_pkg::*;
#(
    parameter int unsigned SE0_CYCLES = SE0_MIN_CYCLES
)(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Detector side of the carrier
    uef_se0_if.det se0_bus
);
    localparam int CW = $clog2(SE0_CYCLES + 1);

    typedef enum logic [1:0] {
        UEF_IDLE = 2'b00,
        UEF_COUNT = 2'b01,
        UEF_HOLD = 2'b10
    } uef_se0_state_t;

    uef_se0_state_t state_ff;
    logic [1:0] dp_sync_ff;
    logic [1:0] dm_sync_ff;
    logic [CW-1:0] cnt_ff;
    logic evt_ff;
    logic hold_ff;
    logic se0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // Idle J has dp high, so no false SE0 follows reset
            dp_sync_ff <= 2'h3;
            dm_sync_ff <= 2'h0;
        end
        else
        begin
            dp_sync_ff <= {dp_sync_ff[0], se0_bus.dp_pin};
            dm_sync_ff <= {dm_sync_ff[0], se0_bus.dm_pin};
        end
    end

    assign se0 = !dp_sync_ff[1] && !dm_sync_ff[1];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= UEF_IDLE;
            cnt_ff <= '0;
            evt_ff <= 1'b0;
            hold_ff <= 1'b0;
        end
        else
        begin
            evt_ff <= 1'b0;
            unique case (state_ff)
                UEF_IDLE:
                begin
                    cnt_ff <= '0;
                    if (se0)
                        state_ff <= UEF_COUNT;
                end
                UEF_COUNT:
                begin
                    if (!se0)
                        state_ff <= UEF_IDLE;
                    else if (cnt_ff == CW'(SE0_CYCLES - 1))
                    begin
                        state_ff <= UEF_HOLD;
                        evt_ff <= 1'b1;
                        hold_ff <= 1'b1;
                    end
                    else
                        cnt_ff <= cnt_ff + 1'b1;
                end
                UEF_HOLD:
                begin
                    if (!se0)
                    begin
                        state_ff <= UEF_IDLE;
                        hold_ff <= 1'b0;
                    end
                end
                default:
                    state_ff <= UEF_IDLE;
            endcase
        end
    end

    assign se0_bus.reset_evt = evt_ff;
    assign se0_bus.in_reset = hold_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    se0_time_a: assert property (evt_ff |-> $past(cnt_ff) == CW'(SE0_CYCLES - 1))
        else $error("bus reset flagged before SE0 time elapsed");
    se0_hold_a: assert property (hold_ff && se0 |=> hold_ff)
        else $error("bus reset state left while SE0 continues");
    se0_end_a: assert property (hold_ff && !se0 |=> !hold_ff ##1 !evt_ff)
        else $error("bus reset state kept after SE0 ended");
    se0_reset_c: cover property (evt_ff ##1 hold_ff [*3]);
endmodule
`default_nettype wire

/* File: pkg/uef_pkg.sv */
// Constants shared by the USB event-flag block and its bus-reset detector.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package uef_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned SE0_MIN_MS = 10;
    localparam int unsigned SE0_MIN_CYCLES = CLK_HZ / 1000 * SE0_MIN_MS;

    // Register indices; byte address is four times the index
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_EVENT_FLAGS = 8'h11;
    localparam logic [7:0] IDX_IRQ_EN = 8'h12;
    localparam logic [7:0] IDX_SYS_EVENTS = 8'h13;
    localparam logic [7:0] IDX_SYS_EN = 8'h14;
    localparam logic [7:0] IDX_BULK_RX = 8'h18;
    localparam logic [7:0] IDX_SRAM_ROUTE = 8'h1c;

    // Reset values
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_SYS = 8'h00;
    localparam logic [5:0] RST_SRAM_ROUTE = 6'h00;

    // usb_event_flags bit positions
    localparam int FLAG_BULK_RX = 0;
    localparam int FLAG_SETUP = 7;

    // System event bit positions
    localparam int SYS_BUS_RESET = 0;
    localparam int SYS_RESUME = 1;
    localparam int SYS_SUPPLY = 2;
    localparam int SYS_POR = 4;

    // Bulk receive control bits
    localparam int BRX_READY_BIT = 7;
    localparam int BRX_ERR_BIT = 3;

    // sram_route_control bit positions
    localparam int ROUTE_FIRST_BULK = 5;
    localparam int ROUTE_SECOND_BULK = 4;

    // Vector codes
    localparam logic [3:0] VEC_NONE = 4'h0;
    localparam logic [3:0] VEC_SETUP = 4'h1;
    localparam logic [3:0] VEC_BULK_RX = 4'h8;
    localparam logic [3:0] VEC_BUS_RESET = 4'h9;
    localparam logic [3:0] VEC_RESUME = 4'ha;
    localparam logic [3:0] VEC_SUPPLY = 4'hf;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: pkg/uef_se0_if.sv */
// Carrier between the event block and its SE0 bus-reset detector.
// Assumes both ends run on the same core clock.
`default_nettype none
interface uef_se0_if;
    logic dp_pin;
    logic dm_pin;
    logic reset_evt;
    logic in_reset;
    modport det (input dp_pin, input dm_pin, output reset_evt, output in_reset);
    modport ctl (output dp_pin, output dm_pin, input reset_evt, input in_reset);
endinterface
`default_nettype wire

/* File: testbench/test_usb_event_flags_and_buffer_route.sv */
// Self-checking bench for the USB event-flag and SRAM routing block.
// Assumes uef_pkg, the carrier and uef_host_model are compiled first.
`default_nettype none
module test_usb_event_flags_and_buffer_route;
    import uef_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, rx_ready, eng_rst;
    logic rx_err, resume_p, supply_p, se0_hold, dp, dm;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_val;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] evt;
    logic [3:0] pins, vec;
    logic [5:0] route;
    int err_total, checked;

    uef_host_model host (.aclk(aclk), .se0_hold(se0_hold), .dp(dp), .dm(dm));

    uef_event_flags #(.SE0_CYCLES(20)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .usb_event_pulses(evt),
        .bulk_rx_data_error_in(rx_err), .resume_pulse(resume_p),
        .supply_rise_pulse(supply_p), .bus_dp_pin(dp), .bus_dm_pin(dm),
        .reset_src_pins(pins), .irq(irq), .irq_vector(vec), .bulk_rx_ready(rx_ready),
        .sram_route(route), .usb_engine_reset(eng_rst)
    );

    initial
    begin
        aclk = 1'h0;
        forever #4 aclk = !aclk;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_edge(inout int n, input string name);
        @(posedge aclk);
        n++;
        if (n > 60)
        begin
            chk(name, 32'h1, 32'h0);
            print_verdict();
        end
    endtask

    task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok))
        begin
            wait_edge(n, "write_accept");
            aw_ok = aw_ok || awready === 1'h1;
            w_ok = w_ok || wready === 1'h1;
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end
        while (bvalid !== 1'h1)
            wait_edge(n, "write_response");
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [7:0] idx);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (arready !== 1'h1)
            wait_edge(n, "read_accept");
        arvalid <= 1'h0;
        while (rvalid !== 1'h1)
            wait_edge(n, "read_response");
        rd_val = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string name);
        axi_rd(idx);
        chk("rresp", 32'(RESP_OKAY), 32'(resp));
        chk(name, exp, rd_val);
    endtask

    // One-cycle engine pulses, then time for flag and irq to settle
    task automatic pulse(input logic [7:0] m, input logic e, input logic r, input logic s);
        @(posedge aclk);
        evt <= m;
        rx_err <= e;
        resume_p <= r;
        supply_p <= s;
        @(posedge aclk);
        evt <= 8'h00;
        rx_err <= 1'h0;
        resume_p <= 1'h0;
        supply_p <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic wait_eng(input logic v);
        int n;
        n = 0;
        checked++;
        while (eng_rst !== v)
            wait_edge(n, "usb_engine_reset");
    endtask

    task automatic t_route();
        logic [7:0] v [4] = '{8'hff, 8'h20, 8'h00, 8'h10};
        for (int i = 0; i < 4; i++)
        begin
            axi_wr(IDX_SRAM_ROUTE, {24'h0, v[i]});
            rd_chk(IDX_SRAM_ROUTE, {24'h0, v[i] & 8'h3f}, "route_reg");
            chk("sram_route", {26'h0, v[i][5:0]}, {26'h0, route});
        end
    endtask

    task automatic t_flags();
        for (int i = 0; i < 8; i++)
        begin
            axi_wr(IDX_IRQ_EN, 32'h1 << i);
            pulse(8'h01 << i, 1'h0, 1'h0, 1'h0);
            chk("irq", 32'h1, {31'h0, irq});
            chk("irq_vector", 32'(8 - i), {28'h0, vec});
            repeat (20) @(posedge aclk);
            rd_chk(IDX_EVENT_FLAGS, 32'h1 << i, "flags");
            axi_wr(IDX_EVENT_FLAGS, 32'h1 << i);
            repeat (3) @(posedge aclk);
            chk("irq", 32'h0, {31'h0, irq});
        end
        axi_wr(IDX_IRQ_EN, 32'h0);
        pulse(8'hff, 1'h0, 1'h0, 1'h0);
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk(IDX_EVENT_FLAGS, 32'hff, "flags");
        axi_wr(IDX_EVENT_FLAGS, 32'hff);
        fork
            axi_wr(IDX_EVENT_FLAGS, 32'h80);
            begin
                repeat (2) @(posedge aclk);
                evt <= 8'h80;
                @(posedge aclk);
                evt <= 8'h00;
            end
        join
        rd_chk(IDX_EVENT_FLAGS, 32'h80, "flags");
        axi_wr(IDX_EVENT_FLAGS, 32'h80);
        rd_chk(IDX_EVENT_FLAGS, 32'h0, "flags");
    endtask

    task automatic t_bulk_rx();
        axi_wr(IDX_BULK_RX, 32'h80);
        chk("bulk_rx_ready", 32'h1, {31'h0, rx_ready});
        pulse(8'h01, 1'h1, 1'h0, 1'h0);
        chk("bulk_rx_ready", 32'h0, {31'h0, rx_ready});
        rd_chk(IDX_BULK_RX, 32'h08, "bulk_rx");
        axi_wr(IDX_BULK_RX, 32'h80);
        pulse(8'h01, 1'h0, 1'h0, 1'h0);
        rd_chk(IDX_BULK_RX, 32'h00, "bulk_rx");
        axi_wr(IDX_EVENT_FLAGS, 32'h1);
    endtask

    task automatic t_system();
        axi_wr(IDX_SYS_EN, 32'h7);
        pulse(8'h00, 1'h0, 1'h1, 1'h0);
        chk("irq_vector", 32'(VEC_RESUME), {28'h0, vec});
        axi_wr(IDX_SYS_EVENTS, 32'h2);
        pulse(8'h00, 1'h0, 1'h0, 1'h1);
        chk("irq_vector", 32'(VEC_SUPPLY), {28'h0, vec});
        axi_wr(IDX_SYS_EVENTS, 32'h4);
        @(posedge aclk);
        se0_hold <= 1'h1;
        repeat (10) @(posedge aclk);
        se0_hold <= 1'h0;
        repeat (6) @(posedge aclk);
        rd_chk(IDX_SYS_EVENTS, 32'h0, "sys_events");
        se0_hold <= 1'h1;
        repeat (40) @(posedge aclk);
        chk("irq_vector", 32'(VEC_BUS_RESET), {28'h0, vec});
        repeat (30) @(posedge aclk);
        chk("usb_engine_reset", 32'h1, {31'h0, eng_rst});
        se0_hold <= 1'h0;
        wait_eng(1'h0);
        rd_chk(IDX_SYS_EVENTS, 32'h1, "sys_events");
        axi_wr(IDX_SYS_EVENTS, 32'h1);
        repeat (3) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        for (int k = 0; k < 4; k++)
        begin
            pins <= 4'h1 << k;
            wait_eng(1'h1);
            pins <= 4'h0;
            wait_eng(1'h0);
            rd_chk(IDX_SYS_EVENTS, 32'h10 << k, "reset_source");
            axi_wr(IDX_SYS_EVENTS, 32'h10 << k);
        end
    endtask

    task automatic t_unmapped();
        axi_wr(8'hff, 32'h3f);
        chk("bresp", 32'(RESP_SLVERR), 32'(resp));
        axi_rd(8'hff);
        chk("rresp", 32'(RESP_SLVERR), 32'(resp));
        chk("rdata", 32'h0, rd_val);
        rd_chk(IDX_SRAM_ROUTE, 32'h10, "route_reg");
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, evt, pins} = '0;
        {rx_err, resume_p, supply_p, se0_hold} = 4'h0;
        err_total = 0;
        checked = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd_chk(IDX_EVENT_FLAGS, 32'h0, "flags");
        rd_chk(IDX_BULK_RX, 32'h0, "bulk_rx");
        rd_chk(IDX_SRAM_ROUTE, 32'h0, "route_reg");
        t_route();
        t_flags();
        t_bulk_rx();
        t_system();
        t_unmapped();
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: testbench/uef_host_model.sv */
// Cable-side host model: keeps the lines in idle J or signals SE0.
// Assumes the bench changes se0_hold on aclk edges.
`default_nettype none
module uef_host_model
(
    // Clock
    input wire logic aclk,
    // Command from the bench
    input wire logic se0_hold,
    // Cable lines
    output logic dp,
    output logic dm
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        dp = 1'h1;
        dm = 1'h0;
    end

    // Both lines low while reset is signalled, else idle J; device side floats
    always @(posedge aclk)
    begin
        dp <= !se0_hold;
        dm <= 1'h0;
    end
endmodule
`default_nettype wire
